// ---- hw/oame_consts.svh ----
// Encoding constants for the OR / move instruction executor
`ifndef OAME_CONSTS_SVH
`define OAME_CONSTS_SVH

`define OAME_INSTR_W 14
`define OAME_DATA_W 8
`define OAME_ADDR_W 7
`define OAME_DEST_BIT 7
`define OAME_LIT_MSB 7
`define OAME_OP_MSB 13
`define OAME_OP_LIT_LSB 8
`define OAME_OP_REG_LSB 8
`define OAME_OP_LOADLIT_LSB 10
`define OAME_OPC_OR_LIT 6'h38
`define OAME_OPC_OR_FILE 6'h04
`define OAME_OPC_MOVE_FILE 6'h08
`define OAME_OPC_LOAD_LIT 4'hC
`define OAME_ACC_RST 8'h00
`define OAME_ZERO_RST 1'b0
`define OAME_OP_TIME_NS 20
`define OAME_CLK_PERIOD_NS 20
`define OAME_OP_CYCLES ((`OAME_OP_TIME_NS + `OAME_CLK_PERIOD_NS - 1) / `OAME_CLK_PERIOD_NS)

`endif

// ---- hw/oame_pkg.sv ----
// Types for the OR / move instruction executor
package oame_pkg;

  typedef enum logic [2:0] {
    OAME_OP_NONE = 3'b000,
    OAME_OP_OR_LIT = 3'b001,
    OAME_OP_OR_FILE = 3'b010,
    OAME_OP_MOVE_FILE = 3'b011,
    OAME_OP_LOAD_LIT = 3'b100
  } oame_op_e;

endpackage : oame_pkg

// ---- hw/oame_decode.sv ----
// Opcode matcher and operand field splitter
`timescale 1ns/1ps
`include "oame_consts.svh"

module oame_decode (
  // Instruction word
  input wire logic [13:0] instr_i,
  // Decoded fields
  output oame_pkg::oame_op_e op_o,
  output logic [7:0] literal_o,
  output logic [6:0] file_addr_o,
  output logic dest_file_o
);

  wire logic [5:0] opc6;
  wire logic [3:0] opc4;
  wire logic hit_or_lit;
  wire logic hit_or_file;
  wire logic hit_move_file;
  wire logic hit_load_lit;

  assign opc6 = instr_i[`OAME_OP_MSB:`OAME_OP_REG_LSB];
  // Bits 9:8 of the load-literal form are ignored
  assign opc4 = instr_i[`OAME_OP_MSB:`OAME_OP_LOADLIT_LSB];
  assign hit_or_lit = (opc6 == `OAME_OPC_OR_LIT);
  assign hit_or_file = (opc6 == `OAME_OPC_OR_FILE);
  assign hit_move_file = (opc6 == `OAME_OPC_MOVE_FILE);
  assign hit_load_lit = (opc4 == `OAME_OPC_LOAD_LIT);

  assign op_o = hit_or_lit ? oame_pkg::OAME_OP_OR_LIT :
                hit_or_file ? oame_pkg::OAME_OP_OR_FILE :
                hit_move_file ? oame_pkg::OAME_OP_MOVE_FILE :
                hit_load_lit ? oame_pkg::OAME_OP_LOAD_LIT :
                oame_pkg::OAME_OP_NONE;
  assign literal_o = instr_i[`OAME_LIT_MSB:0];
  assign file_addr_o = instr_i[`OAME_ADDR_W-1:0];
  assign dest_file_o = instr_i[`OAME_DEST_BIT];

endmodule : oame_decode

// ---- hw/oame_exec.sv ----
// Executes the literal-OR, register-OR, move-file and load-literal instructions
`timescale 1ns/1ps
`include "oame_consts.svh"

module oame_exec (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Instruction issue
  input wire logic [13:0] instr_i,
  input wire logic instr_valid_i,
  // File register read port
  output logic [6:0] file_raddr_o,
  input wire logic [7:0] file_rdata_i,
  // File register write port
  output logic file_we_o,
  output logic [6:0] file_waddr_o,
  output logic [7:0] file_wdata_o,
  // Core state
  output logic [7:0] acc_o,
  output logic zero_flag_o,
  output logic op_done_o
);

  // ==========================================================
  // Decode
  oame_pkg::oame_op_e op;
  logic [7:0] literal;
  logic [6:0] faddr;
  logic dest_file;

  oame_decode u_decode (
    .instr_i(instr_i),
    .op_o(op),
    .literal_o(literal),
    .file_addr_o(faddr),
    .dest_file_o(dest_file)
  );

  // ==========================================================
  // Result selection
  wire logic is_or_lit;
  wire logic is_or_file;
  wire logic is_move;
  wire logic is_load;
  wire logic [7:0] result;
  wire logic to_file;
  wire logic acc_load;
  wire logic zero_load;

  assign is_or_lit = instr_valid_i && (op == oame_pkg::OAME_OP_OR_LIT);
  assign is_or_file = instr_valid_i && (op == oame_pkg::OAME_OP_OR_FILE);
  assign is_move = instr_valid_i && (op == oame_pkg::OAME_OP_MOVE_FILE);
  assign is_load = instr_valid_i && (op == oame_pkg::OAME_OP_LOAD_LIT);

  assign file_raddr_o = faddr;
  assign result = is_or_lit ? (acc_o | literal) :
                  is_or_file ? (acc_o | file_rdata_i) :
                  is_move ? file_rdata_i :
                  literal;
  assign to_file = (is_or_file || is_move) && dest_file;
  assign acc_load = is_or_lit || is_load ||
                    ((is_or_file || is_move) && !dest_file);
  assign zero_load = is_or_lit || is_or_file || is_move;

  // ==========================================================
  // State registers, one cycle per instruction
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic zero_q;
  logic zero_d;
  logic we_q;
  logic [6:0] waddr_q;
  logic [7:0] wdata_q;
  logic done_q;

  assign acc_d = acc_load ? result : acc_q;
  assign zero_d = zero_load ? (result == 8'h00) : zero_q;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_q <= `OAME_ACC_RST;
      zero_q <= `OAME_ZERO_RST;
      we_q <= 1'b0;
      waddr_q <= 7'h00;
      wdata_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      zero_q <= zero_d;
      we_q <= to_file;
      waddr_q <= faddr;
      wdata_q <= result;
      done_q <= is_or_lit || is_or_file || is_move || is_load;
    end
  end

  assign acc_o = acc_q;
  assign zero_flag_o = zero_q;
  assign file_we_o = we_q;
  assign file_waddr_o = waddr_q;
  assign file_wdata_o = wdata_q;
  assign op_done_o = done_q;

  // ==========================================================
  // Checks
  sequence s_or_lit;
    instr_valid_i && instr_i[13:8] == 6'h38;
  endsequence

  sequence s_load;
    instr_valid_i && instr_i[13:10] == 4'hC;
  endsequence

  // Raw opcode match, independent of the decoder
  wire logic chk_known;
  assign chk_known = instr_i[13:8] == 6'h38 || instr_i[13:8] == 6'h04 ||
                     instr_i[13:8] == 6'h08 || instr_i[13:10] == 4'hC;

  sequence s_or_file;
    instr_valid_i && instr_i[13:8] == 6'h04;
  endsequence

  sequence s_move;
    instr_valid_i && instr_i[13:8] == 6'h08;
  endsequence

  sequence s_known;
    instr_valid_i && chk_known;
  endsequence

  sequence s_idle;
    !(instr_valid_i && chk_known);
  endsequence

  or_lit_acc_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    s_or_lit |=> acc_o == ($past(acc_o) | $past(instr_i[7:0])))
    else $error("literal OR result wrong");

  or_lit_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    s_or_lit |=> zero_flag_o == (acc_o == 8'h00))
    else $error("literal OR zero flag wrong");

  or_file_acc_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    instr_valid_i && instr_i[13:8] == 6'h04 && !instr_i[7]
    |=> acc_o == ($past(acc_o) | $past(file_rdata_i)) && zero_flag_o == (acc_o == 8'h00))
    else $error("register OR to accumulator wrong");

  or_file_wb_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    instr_valid_i && instr_i[13:8] == 6'h04 && instr_i[7]
    |=> file_we_o && file_wdata_o == ($past(acc_o) | $past(file_rdata_i))
        && file_waddr_o == $past(instr_i[6:0]) && $stable(acc_o))
    else $error("register OR write-back wrong");

  move_acc_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    instr_valid_i && instr_i[13:8] == 6'h08 && !instr_i[7]
    |=> acc_o == $past(file_rdata_i) && !file_we_o)
    else $error("move to accumulator wrong");

  move_file_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    instr_valid_i && instr_i[13:8] == 6'h08 && instr_i[7]
    |=> file_we_o && file_wdata_o == $past(file_rdata_i) && $stable(acc_o))
    else $error("move write-back wrong");

  move_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    instr_valid_i && instr_i[13:8] == 6'h08
    |=> zero_flag_o == ($past(file_rdata_i) == 8'h00))
    else $error("move zero test wrong");

  load_lit_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    s_load |=> acc_o == $past(instr_i[7:0]) && $stable(zero_flag_o))
    else $error("load literal wrong");

  load_dontcare_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    instr_valid_i && instr_i[13:10] == 4'hC && instr_i[9:8] != 2'h0
    |=> acc_o == $past(instr_i[7:0]) && op_done_o && !file_we_o)
    else $error("load literal with set don't-care bits wrong");

  single_cycle_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    s_known |=> op_done_o)
    else $error("operation not done in one cycle");

  // Side effects and ignored words
  refused_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    s_idle |=> !op_done_o && !file_we_o && $stable(acc_o) && $stable(zero_flag_o))
    else $error("ignored instruction changed state");

  or_lit_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    s_or_lit |=> op_done_o && !file_we_o)
    else $error("literal OR wrote a file register");

  or_file_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    s_or_file |=> zero_flag_o == (($past(acc_o) | $past(file_rdata_i)) == 8'h00))
    else $error("register OR zero flag wrong");

  or_file_nowb_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    instr_valid_i && instr_i[13:8] == 6'h04 && !instr_i[7]
    |=> op_done_o && !file_we_o)
    else $error("register OR to accumulator wrote a file register");

  move_addr_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    s_move ##0 instr_i[7]
    |=> file_waddr_o == $past(instr_i[6:0]) && op_done_o)
    else $error("move write-back address wrong");

  move_wb_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    s_move ##0 instr_i[7]
    |=> zero_flag_o == (file_wdata_o == 8'h00))
    else $error("move write-back zero test wrong");

  load_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    s_load |=> op_done_o && !file_we_o)
    else $error("load literal wrote a file register");

endmodule : oame_exec

// ---- tb/or_and_move_instruction_exec_tb.sv ----
// Self-checking bench for the OR / move instruction executor
`timescale 1ns/1ps
module or_and_move_instruction_exec_tb;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [13:0] instr_i = 14'h0000;
  logic instr_valid_i = 1'b0;
  logic [6:0] file_raddr_o;
  logic [7:0] file_rdata_i;
  logic file_we_o;
  logic [6:0] file_waddr_o;
  logic [7:0] file_wdata_o;
  logic [7:0] acc_o;
  logic zero_flag_o;
  logic op_done_o;
  logic [7:0] mem [0:127];
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  always #10 sys_clk_i = ~sys_clk_i;
  // File model answers reads in the same cycle
  assign file_rdata_i = mem[file_raddr_o];

  oame_exec u_oame_exec (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .instr_i(instr_i),
    .instr_valid_i(instr_valid_i),
    .file_raddr_o(file_raddr_o),
    .file_rdata_i(file_rdata_i),
    .file_we_o(file_we_o),
    .file_waddr_o(file_waddr_o),
    .file_wdata_o(file_wdata_o),
    .acc_o(acc_o),
    .zero_flag_o(zero_flag_o),
    .op_done_o(op_done_o)
  );

  // ==========================================================
  // Checking and issue helpers
  task automatic report_and_stop();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  // Issue one instruction; on return the answering cycle is visible
  task automatic issue(input logic [13:0] w, input logic v);
    @(posedge sys_clk_i);
    #1;
    instr_i = w;
    instr_valid_i = v;
    @(posedge sys_clk_i);
    #1;
    instr_valid_i = 1'b0;
  endtask : issue

  task automatic expect_out(input logic [7:0] a, input logic z, input logic we, input logic d);
    chk8(acc_o, a);
    chk1(zero_flag_o, z);
    chk1(file_we_o, we);
    chk1(op_done_o, d);
  endtask : expect_out

  // ==========================================================
  // Scenarios
  task automatic t_literal();
    issue(14'h339A, 1'b1);
    expect_out(8'h9A, 1'b0, 1'b0, 1'b1);
    issue(14'h3835, 1'b1);
    expect_out(8'hBF, 1'b0, 1'b0, 1'b1);
    issue(14'h3000, 1'b1);
    expect_out(8'h00, 1'b0, 1'b0, 1'b1);
    issue(14'h3800, 1'b1);
    expect_out(8'h00, 1'b1, 1'b0, 1'b1);
    issue(14'h3155, 1'b1);
    expect_out(8'h55, 1'b1, 1'b0, 1'b1);
  endtask : t_literal

  task automatic t_or_file();
    mem[7'h13] = 8'h13;
    mem[7'h7F] = 8'h0C;
    mem[7'h20] = 8'h00;
    issue(14'h3091, 1'b1);
    issue(14'h0413, 1'b1);
    expect_out(8'h93, 1'b0, 1'b0, 1'b1);
    chk8({1'b0, file_raddr_o}, 8'h13);
    issue(14'h04FF, 1'b1);
    expect_out(8'h93, 1'b0, 1'b1, 1'b1);
    chk8({1'b0, file_waddr_o}, 8'h7F);
    chk8(file_wdata_o, 8'h9F);
    issue(14'h3000, 1'b1);
    issue(14'h0420, 1'b1);
    expect_out(8'h00, 1'b1, 1'b0, 1'b1);
  endtask : t_or_file

  task automatic t_move();
    mem[7'h05] = 8'h00;
    mem[7'h6A] = 8'h80;
    issue(14'h38FF, 1'b1);
    issue(14'h0885, 1'b1);
    expect_out(8'hFF, 1'b1, 1'b1, 1'b1);
    chk8({1'b0, file_waddr_o}, 8'h05);
    chk8(file_wdata_o, 8'h00);
    issue(14'h086A, 1'b1);
    expect_out(8'h80, 1'b0, 1'b0, 1'b1);
  endtask : t_move

  task automatic t_refused();
    issue(14'h3811, 1'b0);
    expect_out(8'h80, 1'b0, 1'b0, 1'b0);
    issue(14'h0C11, 1'b1);
    expect_out(8'h80, 1'b0, 1'b0, 1'b0);
  endtask : t_refused

  task automatic t_reset();
    mem[7'h2B] = 8'h5C;
    issue(14'h08AB, 1'b1);
    expect_out(8'h80, 1'b0, 1'b1, 1'b1);
    rstn_i = 1'b0;
    #1;
    expect_out(8'h00, 1'b0, 1'b0, 1'b0);
    chk8({1'b0, file_waddr_o}, 8'h00);
    chk8(file_wdata_o, 8'h00);
    repeat (2) @(posedge sys_clk_i);
    #1;
    rstn_i = 1'b1;
    issue(14'h327E, 1'b1);
    expect_out(8'h7E, 1'b0, 1'b0, 1'b1);
  endtask : t_reset

  // ==========================================================
  // Main sequence and timeout
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    repeat (8) @(posedge sys_clk_i);
    #1;
    rstn_i = 1'b1;
    t_literal();
    t_or_file();
    t_move();
    t_refused();
    t_reset();
    report_and_stop();
  end
endmodule : or_and_move_instruction_exec_tb
